// file: hw/sfm_starter_fault_manager.sv
// The AXI4-Lite register port and the register offsets were left to the implementer.
`default_nettype none
// Operation
// - every fault maps to one of four classes
// - accepted ack clears message, drops ready relay
// - ack ignored while condition still present
// - nonsafe/safe: inhibit, bypass off, blink, show, store
// - nonsafe/safe/processor open status contacts
// - nonsafe/safe set restart lock
// - nonsafe/warning ack: power, enable low, knob
// - external ack only when configured
// - lock lifted by power cycle, enable low
// - safety ack only knob or external input
// - safety lock lifted only after ack
// - warning shows, stores, keeps running
// - processor fault inhibits, lamp steady
// - init failure shows text and stores
// - other processor faults leave display unchanged
// - processor fault cleared only by power cycle
// - any non-processor fault blinks lamp, shows message
// - third brake timeout in row is safety
// - after safety ack timeouts nonsafe again
// - relay mismatch raises safety fault
module sfm_starter_fault_manager #(
  parameter int BLINK_CYC = sfm_pkg::BLINK_CYC    // lamp half period in cycles
) (
  input  wire logic        clk,              // 25 MHz clock
  input  wire logic        srst,             // sync reset, power-on
  input  wire logic        warnFault,        // warning class condition
  input  wire logic        nonSafeFault,     // non-safety class condition
  input  wire logic        procInitFault,    // processor init failure
  input  wire logic        procOtherFault,   // watchdog / other processor error
  input  wire logic        brakeTimeoutFault,// zero speed timeout during braking
  input  wire logic        relayMismatchFault, // relay position mismatch
  input  wire logic        commandEnableInput, // command enable pin
  input  wire logic        externalAckInput,   // external ack pin
  input  wire logic        startRequest,     // request to start motor
  output logic             thyristorInhibit, // power stage inhibit
  output logic             bypassOff,        // bypass relays open
  output logic             readyContact,     // ready contact closed
  output logic             runningContact,   // running contact closed
  output logic             zeroSpeedContact, // zero speed contact closed
  output logic             readyRelayOutput, // ready relay control
  output logic             moduleStatusLamp, // fault lamp drive
  output logic             displayOn,        // message and backlight on
  output logic             storeStrobe,      // store record pulse
  output logic [2:0]       storeClass,       // class of stored record
  output logic             motorStart,       // start granted
  input  wire logic [7:0]  s_axi_awaddr,     // write address
  input  wire logic        s_axi_awvalid,    // write address valid
  output logic             s_axi_awready,    // write address ready
  input  wire logic [31:0] s_axi_wdata,      // write data
  input  wire logic [3:0]  s_axi_wstrb,      // write strobes
  input  wire logic        s_axi_wvalid,     // write data valid
  output logic             s_axi_wready,     // write data ready
  output logic [1:0]       s_axi_bresp,      // write response
  output logic             s_axi_bvalid,     // write response valid
  input  wire logic        s_axi_bready,     // write response ready
  input  wire logic [7:0]  s_axi_araddr,     // read address
  input  wire logic        s_axi_arvalid,    // read address valid
  output logic             s_axi_arready,    // read address ready
  output logic [31:0]      s_axi_rdata,      // read data
  output logic [1:0]       s_axi_rresp,      // read response
  output logic             s_axi_rvalid,     // read data valid
  input  wire logic        s_axi_rready      // read data ready
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [2:0] enSync_r;                      // enable pin chain
  logic [2:0] ackSync_r;                     // ack pin chain
  logic       enState_r, enState_nxt;        // debounced enable level
  logic       ackState_r, ackState_nxt;      // debounced ack level

  // change counts once stages two and three agree
  always_comb begin
    enState_nxt  = (enSync_r[1] == enSync_r[2]) ? enSync_r[2] : enState_r;
    ackState_nxt = (ackSync_r[1] == ackSync_r[2]) ? ackSync_r[2] : ackState_r;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      enSync_r   <= 3'h0;
      ackSync_r  <= 3'h0;
      enState_r  <= 1'b0;
      ackState_r <= 1'b0;
    end else begin
      enSync_r   <= {enSync_r[1:0], commandEnableInput};
      ackSync_r  <= {ackSync_r[1:0], externalAckInput};
      enState_r  <= enState_nxt;
      ackState_r <= ackState_nxt;
    end
  end

  // ----------------------------------------
  // registers and bus
  // ----------------------------------------
  logic        extAckEn_r, extAckEn_nxt;     // external ack enabled
  logic        knobAck_r, knobAck_nxt;       // knob confirm pulse
  logic        awHeld_r, awHeld_nxt;         // address taken
  logic        wHeld_r, wHeld_nxt;           // data taken
  logic [7:0]  awAddr_r, awAddr_nxt;
  logic [31:0] wData_r, wData_nxt;
  logic [3:0]  wStrb_r, wStrb_nxt;
  logic        bValid_r, bValid_nxt;
  logic [1:0]  bResp_r, bResp_nxt;
  logic        rValid_r, rValid_nxt;
  logic [1:0]  rResp_r, rResp_nxt;
  logic [31:0] rData_r, rData_nxt;
  logic [31:0] statusWord;                   // live status view

  // ----------------------------------------
  // fault state
  // ----------------------------------------
  sfm_pkg::sfm_class_t cls_r, cls_nxt;       // latched class
  logic        acked_r, acked_nxt;           // safety fault acknowledged
  logic        lock_r, lock_nxt;             // restart lock
  logic        disp_r, disp_nxt;             // display message on
  logic [1:0]  zsCount_r, zsCount_nxt;       // brake timeout run
  logic        zsPrev_r;                     // timeout edge detect
  logic        enPrev_r, ackPrev_r;          // pin edge detect
  logic        store_r, store_nxt;
  logic [2:0]  storeCls_r, storeCls_nxt;
  logic [31:0] blinkCnt_r, blinkCnt_nxt;
  logic        blink_r, blink_nxt;
  logic        start_r, start_nxt;
  logic        readyRly_r, readyRly_nxt;
  sfm_pkg::sfm_class_t newCls;
  logic        condPresent, enFall, extAck, anyAck, powerAck;
  logic        zsEdge, zsSafe;

  // new fault class and acknowledge sources
  always_comb begin
    zsEdge = brakeTimeoutFault && !zsPrev_r;
    zsSafe = zsEdge && (zsCount_r == 2'(sfm_pkg::ZS_LIMIT - 1));
    enFall = enPrev_r && !enState_r;
    extAck = extAckEn_r && ackState_r && !ackPrev_r;
    powerAck = 1'b0;                          // power cycle acts through srst
    // severity priority
    if (procInitFault || procOtherFault)                       newCls = sfm_pkg::CLS_PROC;
    else if (relayMismatchFault || zsSafe)                     newCls = sfm_pkg::CLS_SAFE;
    else if (nonSafeFault || zsEdge)                           newCls = sfm_pkg::CLS_NONSAFE;
    else if (warnFault)                                        newCls = sfm_pkg::CLS_WARN;
    else                                                       newCls = sfm_pkg::CLS_NONE;
    condPresent = warnFault || nonSafeFault || relayMismatchFault || brakeTimeoutFault;
    case (cls_r)
      sfm_pkg::CLS_WARN, sfm_pkg::CLS_NONSAFE: anyAck = enFall || knobAck_r || extAck || powerAck;
      sfm_pkg::CLS_SAFE:                       anyAck = knobAck_r || extAck;
      default:                                 anyAck = 1'b0;
    endcase
    anyAck = anyAck && !condPresent;
  end

  // class latch, acknowledgement and restart lock
  always_comb begin
    cls_nxt      = cls_r;
    acked_nxt    = acked_r;
    lock_nxt     = lock_r;
    disp_nxt     = disp_r;
    zsCount_nxt  = zsCount_r;
    store_nxt    = 1'b0;
    storeCls_nxt = storeCls_r;
    readyRly_nxt = readyRly_r;
    // lock release on enable falling edge; safety needs prior ack
    // evaluated first so a fault latched in the same cycle keeps its lock
    if (enFall && lock_r && cls_r != sfm_pkg::CLS_SAFE && cls_r != sfm_pkg::CLS_PROC) begin
      lock_nxt  = 1'b0;
      acked_nxt = 1'b0;
    end
    if (zsEdge && !zsSafe) begin
      zsCount_nxt = zsCount_r + 2'h1;
    end
    if (newCls > cls_r && !(cls_r == sfm_pkg::CLS_SAFE && acked_r == 1'b0 && newCls < cls_r)) begin
      cls_nxt      = newCls;
      acked_nxt    = 1'b0;
      store_nxt    = !(newCls == sfm_pkg::CLS_PROC && !procInitFault);
      storeCls_nxt = 3'(newCls);
      readyRly_nxt = 1'b1;
      if (newCls != sfm_pkg::CLS_PROC || procInitFault) begin
        disp_nxt = 1'b1;
      end
      if (newCls == sfm_pkg::CLS_NONSAFE || newCls == sfm_pkg::CLS_SAFE) begin
        lock_nxt = 1'b1;
      end
    end else if (anyAck) begin
      if (cls_r == sfm_pkg::CLS_SAFE) begin
        acked_nxt   = 1'b1;
        zsCount_nxt = 2'h0;
      end
      cls_nxt      = sfm_pkg::CLS_NONE;
      disp_nxt     = 1'b0;
      readyRly_nxt = 1'b0;
    end
  end

  // lamp blink divider and start gating
  always_comb begin
    blinkCnt_nxt = blinkCnt_r + 32'h1;
    blink_nxt    = blink_r;
    if (blinkCnt_r >= 32'(BLINK_CYC - 1)) begin
      blinkCnt_nxt = 32'h0;
      blink_nxt    = !blink_r;
    end
    start_nxt = startRequest && !lock_r && cls_r != sfm_pkg::CLS_PROC;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cls_r      <= sfm_pkg::CLS_NONE;
      acked_r    <= 1'b0;
      lock_r     <= 1'b0;
      disp_r     <= 1'b0;
      zsCount_r  <= 2'h0;
      zsPrev_r   <= 1'b0;
      enPrev_r   <= 1'b0;
      ackPrev_r  <= 1'b0;
      store_r    <= 1'b0;
      storeCls_r <= 3'h0;
      blinkCnt_r <= 32'h0;
      blink_r    <= 1'b0;
      start_r    <= 1'b0;
      readyRly_r <= 1'b0;
    end else begin
      cls_r      <= cls_nxt;
      acked_r    <= acked_nxt;
      lock_r     <= lock_nxt;
      disp_r     <= disp_nxt;
      zsCount_r  <= zsCount_nxt;
      zsPrev_r   <= brakeTimeoutFault;
      enPrev_r   <= enState_r;
      ackPrev_r  <= ackState_r;
      store_r    <= store_nxt;
      storeCls_r <= storeCls_nxt;
      blinkCnt_r <= blinkCnt_nxt;
      blink_r    <= blink_nxt;
      start_r    <= start_nxt;
      readyRly_r <= readyRly_nxt;
    end
  end

  // ----------------------------------------
  // class driven outputs
  // ----------------------------------------
  logic stopCls;                              // class that stops the drive
  always_comb begin
    stopCls = cls_r == sfm_pkg::CLS_NONSAFE || cls_r == sfm_pkg::CLS_SAFE || cls_r == sfm_pkg::CLS_PROC;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      thyristorInhibit <= 1'b0;
      bypassOff        <= 1'b0;
      readyContact     <= 1'b0;
      runningContact   <= 1'b0;
      zeroSpeedContact <= 1'b0;
      moduleStatusLamp <= 1'b0;
    end else begin
      thyristorInhibit <= stopCls;
      bypassOff        <= stopCls;
      readyContact     <= !stopCls;
      runningContact   <= !stopCls && start_r;
      zeroSpeedContact <= !stopCls && !start_r;
      moduleStatusLamp <= (cls_r == sfm_pkg::CLS_PROC) ? 1'b1 :
                          (cls_r != sfm_pkg::CLS_NONE) ? blink_r : 1'b0;
    end
  end

  assign readyRelayOutput = readyRly_r;
  assign displayOn        = disp_r;
  assign storeStrobe      = store_r;
  assign storeClass       = storeCls_r;
  assign motorStart       = start_r;

  // ----------------------------------------
  // axi4-lite slave
  // ----------------------------------------
  always_comb begin
    statusWord = 32'h0;
    statusWord[sfm_pkg::ST_INHIBIT]    = thyristorInhibit;
    statusWord[sfm_pkg::ST_BYPASS_OFF] = bypassOff;
    statusWord[sfm_pkg::ST_LOCK]       = lock_r;
    statusWord[sfm_pkg::ST_DISPLAY]    = disp_r;
    statusWord[sfm_pkg::ST_ACKED]      = acked_r;
    statusWord[sfm_pkg::ST_READY_RLY]  = readyRly_r;
    awHeld_nxt  = awHeld_r;
    wHeld_nxt   = wHeld_r;
    awAddr_nxt  = awAddr_r;
    wData_nxt   = wData_r;
    wStrb_nxt   = wStrb_r;
    bValid_nxt  = bValid_r;
    bResp_nxt   = bResp_r;
    extAckEn_nxt = extAckEn_r;
    knobAck_nxt = 1'b0;
    if (s_axi_awvalid && !awHeld_r && !bValid_r) begin
      awHeld_nxt = 1'b1;
      awAddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && !wHeld_r && !bValid_r) begin
      wHeld_nxt = 1'b1;
      wData_nxt = s_axi_wdata;
      wStrb_nxt = s_axi_wstrb;
    end
    if (awHeld_r && wHeld_r) begin
      awHeld_nxt = 1'b0;
      wHeld_nxt  = 1'b0;
      bValid_nxt = 1'b1;
      bResp_nxt  = sfm_pkg::RESP_OKAY;
      if (awAddr_r == sfm_pkg::ADDR_CTRL) begin
        if (wStrb_r[0]) begin
          extAckEn_nxt = wData_r[sfm_pkg::CTRL_EXTACK_EN];
          knobAck_nxt  = wData_r[sfm_pkg::CTRL_KNOB_ACK];
        end
      end else if (awAddr_r != sfm_pkg::ADDR_STATUS && awAddr_r != sfm_pkg::ADDR_CLASS) begin
        bResp_nxt = sfm_pkg::RESP_SLVERR;
      end
    end else if (bValid_r && s_axi_bready) begin
      bValid_nxt = 1'b0;
    end
    rValid_nxt = rValid_r;
    rData_nxt  = rData_r;
    rResp_nxt  = rResp_r;
    if (s_axi_arvalid && !rValid_r) begin
      rValid_nxt = 1'b1;
      rResp_nxt  = sfm_pkg::RESP_OKAY;
      case (s_axi_araddr)
        sfm_pkg::ADDR_CTRL:   rData_nxt = {31'h0, extAckEn_r};
        sfm_pkg::ADDR_STATUS: rData_nxt = statusWord;
        sfm_pkg::ADDR_CLASS:  rData_nxt = {29'h0, 3'(cls_r)};
        default: begin
          rData_nxt = 32'h0;
          rResp_nxt = sfm_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rValid_r && s_axi_rready) begin
      rValid_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      awHeld_r   <= 1'b0;
      wHeld_r    <= 1'b0;
      awAddr_r   <= 8'h00;
      wData_r    <= 32'h0;
      wStrb_r    <= 4'h0;
      bValid_r   <= 1'b0;
      bResp_r    <= 2'h0;
      rValid_r   <= 1'b0;
      rResp_r    <= 2'h0;
      rData_r    <= 32'h0;
      extAckEn_r <= sfm_pkg::CTRL_RST[sfm_pkg::CTRL_EXTACK_EN];
      knobAck_r  <= 1'b0;
    end else begin
      awHeld_r   <= awHeld_nxt;
      wHeld_r    <= wHeld_nxt;
      awAddr_r   <= awAddr_nxt;
      wData_r    <= wData_nxt;
      wStrb_r    <= wStrb_nxt;
      bValid_r   <= bValid_nxt;
      bResp_r    <= bResp_nxt;
      rValid_r   <= rValid_nxt;
      rResp_r    <= rResp_nxt;
      rData_r    <= rData_nxt;
      extAckEn_r <= extAckEn_nxt;
      knobAck_r  <= knobAck_nxt;
    end
  end

  assign s_axi_awready = s_axi_awvalid && !awHeld_r && !bValid_r;
  assign s_axi_wready  = s_axi_wvalid && !wHeld_r && !bValid_r;
  assign s_axi_bvalid  = bValid_r;
  assign s_axi_bresp   = bResp_r;
  assign s_axi_arready = s_axi_arvalid && !rValid_r;
  assign s_axi_rvalid  = rValid_r;
  assign s_axi_rdata   = rData_r;
  assign s_axi_rresp   = rResp_r;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  stop_inhibit_a: assert property (stopCls |=> thyristorInhibit && bypassOff)
    else $error("drive not stopped on fault");
  contacts_open_a: assert property (stopCls |=> !readyContact && !runningContact)
    else $error("status contacts closed on fault");
  lock_set_a: assert property ((newCls == sfm_pkg::CLS_NONSAFE || newCls == sfm_pkg::CLS_SAFE) && newCls > cls_r
                               |=> lock_r)
    else $error("restart lock missing");
  ack_clear_a: assert property (anyAck && newCls <= cls_r |=> !disp_r && !readyRly_r)
    else $error("ack left message");
  ack_blocked_a: assert property (condPresent && cls_r != sfm_pkg::CLS_NONE && newCls <= cls_r
                                  |=> cls_r == $past(cls_r))
    else $error("ack taken while fault present");
  proc_sticky_a: assert property (cls_r == sfm_pkg::CLS_PROC |=> cls_r == sfm_pkg::CLS_PROC)
    else $error("processor fault cleared");
  proc_lamp_a: assert property (cls_r == sfm_pkg::CLS_PROC |=> moduleStatusLamp)
    else $error("lamp not steady");
  warn_run_a: assert property (cls_r == sfm_pkg::CLS_WARN |=> !thyristorInhibit)
    else $error("warning stopped drive");
  safe_enable_a: assert property (cls_r == sfm_pkg::CLS_SAFE && !knobAck_r && !extAck && newCls != sfm_pkg::CLS_PROC
                                  |=> cls_r == sfm_pkg::CLS_SAFE)
    else $error("safety fault acked wrongly");

  warn_cov_c: cover property (cls_r == sfm_pkg::CLS_WARN ##1 cls_r == sfm_pkg::CLS_NONE);
  safe_cov_c: cover property (cls_r == sfm_pkg::CLS_SAFE ##[1:20] acked_r);
  proc_cov_c: cover property (cls_r == sfm_pkg::CLS_PROC);
endmodule
`default_nettype wire

// file: hw/sfm_pkg.sv
`default_nettype none
package sfm_pkg;
  // ----------------------------------------
  // fault classes, ordered by severity
  // ----------------------------------------
  typedef enum logic [2:0] {
    CLS_NONE,
    CLS_WARN,
    CLS_NONSAFE,
    CLS_SAFE,
    CLS_PROC
  } sfm_class_t;

  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;   // control / config
  localparam logic [7:0] ADDR_STATUS = 8'h04;   // live state
  localparam logic [7:0] ADDR_CLASS  = 8'h08;   // latched fault class

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CTRL_EXTACK_EN = 0;            // enable external ack input
  localparam int CTRL_KNOB_ACK  = 1;            // knob confirm strobe (self-clearing)

  localparam int ST_INHIBIT     = 0;
  localparam int ST_BYPASS_OFF  = 1;
  localparam int ST_LOCK        = 2;
  localparam int ST_DISPLAY     = 3;
  localparam int ST_ACKED       = 4;
  localparam int ST_READY_RLY   = 5;

  // ----------------------------------------
  // reset values and timing
  // ----------------------------------------
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam int          CLK_HZ     = 25_000_000;
  localparam int          BLINK_MS   = 250;        // lamp half period
  localparam int          BLINK_CYC  = CLK_HZ / 1000 * BLINK_MS;
  localparam int          ZS_LIMIT   = 3;          // brake timeouts before safety class
  localparam logic [1:0]  RESP_OKAY  = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;
endpackage
`default_nettype wire

// file: verif/sfm_panel_model.sv
`default_nettype none
// ----------------------------------------
// plant control pins seen by the starter
// ----------------------------------------
module sfm_panel_model (
  input  wire logic clk,                // system clock
  input  wire logic enReq,              // bench wish for enable level
  input  wire logic ackReq,             // bench wish for ack button
  output var  logic commandEnableInput, // enable pin to the starter
  output var  logic externalAckInput    // ack pin to the starter
);
  timeunit 1ns;
  timeprecision 1ps;
  // pins start released, as after a cold start
  initial begin
    commandEnableInput = 1'b0;
    externalAckInput   = 1'b0;
  end
  // pins follow the operator one cycle late, like a slow relay contact
  always @(posedge clk) begin
    commandEnableInput <= enReq;
    externalAckInput   <= ackReq;
  end
endmodule
`default_nettype wire

// file: verif/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        clk, srst, warnFault, nonSafeFault, procInitFault, procOtherFault, brakeTimeoutFault;
  logic        relayMismatchFault, commandEnableInput, externalAckInput, startRequest, enReq, ackReq;
  logic        thyristorInhibit, bypassOff, readyContact, runningContact, zeroSpeedContact;
  logic        readyRelayOutput, moduleStatusLamp, displayOn, storeStrobe, motorStart;
  logic [2:0]  storeClass;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int          fail_count = 0, n_tests = 0, nStore = 0, hi, tg;
  // ----------------------------------------
  // design and pin model
  // ----------------------------------------
  sfm_starter_fault_manager #(.BLINK_CYC(4)) DUT (.clk, .srst, .warnFault, .nonSafeFault, .procInitFault,
    .procOtherFault, .brakeTimeoutFault, .relayMismatchFault, .commandEnableInput, .externalAckInput,
    .startRequest, .thyristorInhibit, .bypassOff, .readyContact, .runningContact, .zeroSpeedContact,
    .readyRelayOutput, .moduleStatusLamp, .displayOn, .storeStrobe, .storeClass, .motorStart,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  sfm_panel_model PANEL (.clk, .enReq, .ackReq, .commandEnableInput, .externalAckInput);
  // clock, 40 ns period
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // count stored records
  always @(posedge clk) if (storeStrobe === 1'b1) nStore <= nStore + 1;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // bus write: ready sampled before the edge that takes it
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    logic ta, tw, tb;
    logic [1:0] rb;
    @(posedge clk);
    s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    do begin
      @(negedge clk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid;
      rb = s_axi_bresp;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end while (tb !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(rb, sfm_pkg::RESP_OKAY);
  endtask
  // bus read: data and response taken at the edge rvalid is seen
  task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic ta, got;
    @(posedge clk);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    do begin
      @(negedge clk);
      ta = s_axi_arvalid & s_axi_arready;
      got = s_axi_rvalid;
      v = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge clk);
      if (ta) s_axi_arvalid <= 1'b0;
    end while (got !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    axr(a, d, r);
    chk(d & m, e);
  endtask
  // panel knob confirm, keeping the ack-input enable bit
  task automatic knob(input logic cfg);
    axw(sfm_pkg::ADDR_CTRL, {30'h0000_0000, 1'b1, cfg});
    cyc(6);
  endtask
  task automatic pulse(input int sel);
    @(posedge clk) if (sel == 0) enReq <= 1'b0; else ackReq <= 1'b1;
    cyc(10);
    @(posedge clk) if (sel == 0) enReq <= 1'b1; else ackReq <= 1'b0;
    cyc(10);
  endtask
  // lamp activity over twelve cycles
  task automatic lampc;
    logic p;
    hi = 0; tg = 0; p = moduleStatusLamp;
    repeat (12) begin
      @(negedge clk);
      hi += int'(moduleStatusLamp === 1'b1);
      tg += int'(moduleStatusLamp !== p);
      p = moduleStatusLamp;
    end
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    close_out();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    {srst, warnFault, nonSafeFault, procInitFault, procOtherFault, brakeTimeoutFault} = 6'b10_0000;
    {relayMismatchFault, startRequest, enReq, ackReq, s_axi_awvalid, s_axi_wvalid} = 6'b00_1000;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'b000;
    s_axi_awaddr = 8'h00; s_axi_araddr = 8'h00; s_axi_wdata = 32'h0000_0000; s_axi_wstrb = 4'hF;
    cyc(7);
    @(posedge clk) srst <= 1'b0;
    chk(thyristorInhibit, 1'b0);
    rchk(sfm_pkg::ADDR_CLASS, 32'h0000_0007, 32'h0000_0000);
    axr(8'h0C, d, r);
    chk(d, 32'h0000_0000);
    chk(r, sfm_pkg::RESP_SLVERR);
    @(posedge clk) startRequest <= 1'b1;
    cyc(10);
    chk(motorStart, 1'b1);
    // non-safety fault, early knob ack refused, then accepted
    @(posedge clk) nonSafeFault <= 1'b1;
    cyc(8);
    chk({thyristorInhibit, bypassOff, displayOn, motorStart}, 4'b1110);
    chk({readyContact, runningContact, zeroSpeedContact}, 3'b000);
    chk(nStore, 1);
    lampc();
    chk(tg >= 2, 1'b1);
    knob(1'b0);
    rchk(sfm_pkg::ADDR_CLASS, 32'h0000_0007, 32'h0000_0002);
    @(posedge clk) nonSafeFault <= 1'b0;
    cyc(6);
    knob(1'b0);
    rchk(sfm_pkg::ADDR_STATUS, 32'h0000_0034, 32'h0000_0004);
    chk({displayOn, readyRelayOutput}, 2'b00);
    pulse(0);
    rchk(sfm_pkg::ADDR_STATUS, 32'h0000_0004, 32'h0000_0000);
    // safety fault from relay mismatch: enable and unconfigured input refused
    @(posedge clk) relayMismatchFault <= 1'b1;
    cyc(8);
    @(posedge clk) relayMismatchFault <= 1'b0;
    pulse(0);
    rchk(sfm_pkg::ADDR_CLASS, 32'h0000_0007, 32'h0000_0003);
    pulse(1);
    rchk(sfm_pkg::ADDR_CLASS, 32'h0000_0007, 32'h0000_0003);
    axw(sfm_pkg::ADDR_CTRL, 32'h0000_0001);
    pulse(1);
    rchk(sfm_pkg::ADDR_STATUS, 32'h0000_0014, 32'h0000_0014);
    pulse(0);
    rchk(sfm_pkg::ADDR_STATUS, 32'h0000_0004, 32'h0000_0000);
    // warning with ack input held: no level ack, enable edge acks
    @(posedge clk) ackReq <= 1'b1;
    @(posedge clk) warnFault <= 1'b1;
    cyc(8);
    chk({thyristorInhibit, displayOn, motorStart}, 3'b011);
    @(posedge clk) warnFault <= 1'b0;
    cyc(8);
    rchk(sfm_pkg::ADDR_CLASS, 32'h0000_0007, 32'h0000_0001);
    @(posedge clk) ackReq <= 1'b0;
    pulse(0);
    rchk(sfm_pkg::ADDR_CLASS, 32'h0000_0007, 32'h0000_0000);
    // three brake timeouts give safety class, then non-safety again
    repeat (3) begin
      @(posedge clk) brakeTimeoutFault <= 1'b1;
      cyc(4);
      @(posedge clk) brakeTimeoutFault <= 1'b0;
      cyc(4);
    end
    rchk(sfm_pkg::ADDR_CLASS, 32'h0000_0007, 32'h0000_0003);
    knob(1'b1);
    @(posedge clk) brakeTimeoutFault <= 1'b1;
    cyc(8);
    rchk(sfm_pkg::ADDR_CLASS, 32'h0000_0007, 32'h0000_0002);
    @(posedge clk) brakeTimeoutFault <= 1'b0;
    knob(1'b1);
    pulse(0);
    // processor fault beside a warning: steady lamp, no ack
    @(posedge clk) {procOtherFault, warnFault} <= 2'b11;
    cyc(8);
    rchk(sfm_pkg::ADDR_CLASS, 32'h0000_0007, 32'h0000_0004);
    lampc();
    chk(hi, 32'd12);
    chk({displayOn, thyristorInhibit, readyContact}, 3'b010);
    @(posedge clk) {procOtherFault, warnFault} <= 2'b00;
    cyc(6);
    knob(1'b1);
    pulse(0);
    rchk(sfm_pkg::ADDR_CLASS, 32'h0000_0007, 32'h0000_0004);
    @(posedge clk) srst <= 1'b1;
    @(posedge clk) srst <= 1'b0;
    rchk(sfm_pkg::ADDR_CLASS, 32'h0000_0007, 32'h0000_0000);
    hi = nStore;
    @(posedge clk) procInitFault <= 1'b1;
    cyc(8);
    chk({displayOn, storeClass, nStore == hi + 1}, 5'b1_100_1);
    close_out();
  end
endmodule
`default_nettype wire
